// ===== hw/otppa_top.sv
`timescale 1ns/1ps
// Behaviour
// - processor runs only while the test/programming pin is low
// - run mode maps array at 4000h-7EFFh and FFF00h-FFFFFh
// - programming mode shows array contiguously at 0 to 3FFFh
// - static data memory of 512 bytes plus 128 bytes
// - single-clock operating mode after every reset release
// - programming takes 17-bit address and 8-bit two-way data
// - chip select, output enable, program strobe, mode control inputs
// - one 0.1 ms low program pulse writes the addressed byte
module otppa_top
	import otppa_pkg::*;
#(
	parameter int PULSE_CYC = OTPPA_PULSE_CYC
)(
	input wire logic I_CLK, // 50 MHz clock
	input wire logic I_SYS_RST, // async reset, high
	input wire logic I_TEST_PIN, // test/programming pin level
	input wire logic I_STRAP_HI, // setting pins sampled high
	input wire logic I_STRAP_LO, // setting pins sampled low
	input wire logic I_RESET_PIN, // device reset pin level
	input wire logic [OTPPA_CAW-1:0] I_CPU_ADDR, // processor address
	input wire logic I_CPU_RD, // processor read strobe
	input wire logic I_CPU_WR, // processor ram write
	input wire logic [OTPPA_DW-1:0] I_CPU_WDATA, // processor write data
	input wire logic [OTPPA_PAW-1:0] I_PROG_ADDR, // programmer address
	input wire logic [OTPPA_DW-1:0] I_DATA_IN, // data pins in
	input wire logic I_CHIP_SEL_N, // chip select, low
	input wire logic I_OUT_EN_N, // output enable, low
	input wire logic I_PROGRAM_STROBE_N, // program strobe, low
	input wire logic I_PROG_MODE_CONTROL_IN, // programming-mode control
	output logic [OTPPA_DW-1:0] O_DATA_OUT, // data pins out
	output logic O_DATA_OE, // data pins enable
	output logic [OTPPA_DW-1:0] O_CPU_RDATA, // processor read data
	output logic O_CPU_HIT, // address decoded
	output logic O_CPU_RUN, // processor released
	output logic O_ARRAY_PROGRAM_MODE, // programming mode active
	output logic O_SINGLE_CLK // single-clock mode
);
	// ----------------------------------------
	// storage
	// ----------------------------------------
	logic [OTPPA_DW-1:0] array_mem [OTPPA_ARRAY_BYTES];
	logic [OTPPA_DW-1:0] ram0 [OTPPA_RAM0_BYTES];
	logic [OTPPA_DW-1:0] ram1 [OTPPA_RAM1_BYTES];
	initial if (PULSE_CYC < 1) $error("PULSE_CYC must be at least 1");
	// ----------------------------------------
	// mode and address decode
	// ----------------------------------------
	function automatic logic in_range(input logic [19:0] a, input logic [19:0] lo, input logic [19:0] hi);
		in_range = (a >= lo) && (a <= hi);
	endfunction
	logic prog_mode_q;
	logic prog_sel;
	logic run_ok;
	logic hit_lo;
	logic hit_hi;
	logic hit_r0;
	logic hit_r1;
	logic [OTPPA_AW-1:0] cpu_idx;
	logic [OTPPA_AW-1:0] prog_idx;
	logic prog_in_array;
	logic drive;
	logic fire;
	assign prog_sel = I_TEST_PIN && I_STRAP_HI && !I_STRAP_LO && !I_RESET_PIN && I_PROG_MODE_CONTROL_IN;
	assign run_ok = !I_TEST_PIN && I_RESET_PIN;
	assign hit_lo = in_range(I_CPU_ADDR, OTPPA_LO_BASE, OTPPA_LO_LAST);
	assign hit_hi = in_range(I_CPU_ADDR, OTPPA_HI_BASE, OTPPA_HI_LAST);
	assign hit_r0 = in_range(I_CPU_ADDR, OTPPA_RAM0_BASE, OTPPA_RAM0_BASE + 20'(OTPPA_RAM0_BYTES - 1));
	assign hit_r1 = in_range(I_CPU_ADDR, OTPPA_RAM1_BASE, OTPPA_RAM1_BASE + 20'(OTPPA_RAM1_BYTES - 1));
	// high window lands in the top 256 bytes of the array
	assign cpu_idx = hit_hi ? (OTPPA_HI_SLOT | {6'h00, I_CPU_ADDR[7:0]})
		: OTPPA_AW'(I_CPU_ADDR - OTPPA_LO_BASE);
	assign prog_in_array = (I_PROG_ADDR <= OTPPA_PROG_LAST);
	assign prog_idx = I_PROG_ADDR[OTPPA_AW-1:0];
	assign drive = prog_mode_q && !I_CHIP_SEL_N && !I_OUT_EN_N && I_PROGRAM_STROBE_N;
	// ----------------------------------------
	// program pulse
	// ----------------------------------------
	otppa_pulse_det #(
		.MIN_CYC(PULSE_CYC)
	) u_pulse (
		.i_clk(I_CLK),
		.i_rst(I_SYS_RST),
		.i_strobe_n(I_PROGRAM_STROBE_N),
		.i_armed(prog_mode_q && !I_CHIP_SEL_N && prog_in_array),
		.o_fire(fire)
	);
	// ----------------------------------------
	// state
	// ----------------------------------------
	always_ff @(posedge I_CLK or posedge I_SYS_RST)
	begin
		if (I_SYS_RST)
		begin
			prog_mode_q <= 1'b0;
			O_CPU_RUN <= 1'b0;
			O_ARRAY_PROGRAM_MODE <= 1'b0;
			O_SINGLE_CLK <= 1'b1;
			O_DATA_OE <= 1'b0;
			O_DATA_OUT <= '0;
			O_CPU_RDATA <= '0;
			O_CPU_HIT <= 1'b0;
		end
		else
		begin
			prog_mode_q <= prog_sel;
			O_ARRAY_PROGRAM_MODE <= prog_sel;
			O_CPU_RUN <= run_ok;
			// clock mode switching belongs to the core; here it only restarts single
			if (!run_ok)
				O_SINGLE_CLK <= 1'b1;
			O_DATA_OE <= drive;
			O_DATA_OUT <= drive ? (prog_in_array ? array_mem[prog_idx] : OTPPA_BLANK) : '0;
			O_CPU_HIT <= O_CPU_RUN && I_CPU_RD && (hit_lo || hit_hi || hit_r0 || hit_r1);
			if (O_CPU_RUN && I_CPU_RD)
			begin
				if (hit_lo || hit_hi)
					O_CPU_RDATA <= array_mem[cpu_idx];
				else if (hit_r0)
					O_CPU_RDATA <= ram0[I_CPU_ADDR[8:0] - OTPPA_RAM0_BASE[8:0]];
				else if (hit_r1)
					O_CPU_RDATA <= ram1[I_CPU_ADDR[6:0]];
				else
					O_CPU_RDATA <= '0;
			end
		end
	end
	// otp cells only ever clear bits: a write ands data into the cell
	always_ff @(posedge I_CLK)
	begin
		if (fire)
			array_mem[prog_idx] <= array_mem[prog_idx] & I_DATA_IN;
		if (O_CPU_RUN && I_CPU_WR && hit_r0)
			ram0[I_CPU_ADDR[8:0] - OTPPA_RAM0_BASE[8:0]] <= I_CPU_WDATA;
		if (O_CPU_RUN && I_CPU_WR && hit_r1)
			ram1[I_CPU_ADDR[6:0]] <= I_CPU_WDATA;
	end
	// ----------------------------------------
	// checks
	// ----------------------------------------
	run_gate_a: assert property (@(posedge I_CLK) disable iff (I_SYS_RST) O_CPU_RUN |-> !$past(I_TEST_PIN))
		else $error("processor ran with test pin high");
	oe_gate_a: assert property (@(posedge I_CLK) disable iff (I_SYS_RST) O_DATA_OE |-> $past(!I_CHIP_SEL_N && !I_OUT_EN_N))
		else $error("data driven without select and enable");
	oe_mode_a: assert property (@(posedge I_CLK) disable iff (I_SYS_RST) O_DATA_OE |-> $past(prog_mode_q))
		else $error("data driven outside programming mode");
	single_clk_a: assert property (@(posedge I_CLK) disable iff (I_SYS_RST) $rose(O_CPU_RUN) |-> O_SINGLE_CLK)
		else $error("run began outside single-clock mode");
	fire_mode_a: assert property (@(posedge I_CLK) disable iff (I_SYS_RST) fire |-> $past(prog_mode_q))
		else $error("write outside programming mode");
	fire_edge_a: assert property (@(posedge I_CLK) disable iff (I_SYS_RST) fire |-> $past(I_PROGRAM_STROBE_N) && !$past(I_PROGRAM_STROBE_N, 2))
		else $error("write without strobe release");
	hi_map_a: assert property (@(posedge I_CLK) disable iff (I_SYS_RST) hit_hi |-> cpu_idx[13:8] == 6'h3F)
		else $error("high window mapped wrong");
	lo_map_a: assert property (@(posedge I_CLK) disable iff (I_SYS_RST) (hit_lo && !hit_hi) |-> cpu_idx == I_CPU_ADDR[13:0])
		else $error("low window mapped wrong");
	prog_map_a: assert property (@(posedge I_CLK) disable iff (I_SYS_RST) prog_in_array |-> prog_idx == I_PROG_ADDR[13:0])
		else $error("programming address mapped wrong");
endmodule

// ===== hw/otppa_pkg.sv
package otppa_pkg;
	// ----------------------------------------
	// array geometry
	// ----------------------------------------
	localparam int OTPPA_ARRAY_BYTES = 16384;
	localparam int OTPPA_AW = 14;
	localparam int OTPPA_PAW = 17;
	localparam int OTPPA_CAW = 20;
	localparam int OTPPA_DW = 8;
	localparam logic [19:0] OTPPA_LO_BASE = 20'h04000;
	localparam logic [19:0] OTPPA_LO_LAST = 20'h07EFF;
	localparam logic [19:0] OTPPA_HI_BASE = 20'hFFF00;
	localparam logic [19:0] OTPPA_HI_LAST = 20'hFFFFF;
	localparam logic [13:0] OTPPA_HI_SLOT = 14'h3F00;
	localparam logic [16:0] OTPPA_PROG_LAST = 17'h03FFF;
	localparam logic [7:0] OTPPA_BLANK = 8'hFF;
	// ----------------------------------------
	// data memory
	// ----------------------------------------
	localparam int OTPPA_RAM0_BYTES = 512;
	localparam int OTPPA_RAM1_BYTES = 128;
	localparam logic [19:0] OTPPA_RAM0_BASE = 20'h00040;
	localparam logic [19:0] OTPPA_RAM1_BASE = 20'h00F00;
	// ----------------------------------------
	// timing
	// ----------------------------------------
	localparam int OTPPA_CLK_MHZ = 50;
	localparam int OTPPA_PULSE_US = 100;
	localparam int OTPPA_PULSE_CYC = OTPPA_PULSE_US * OTPPA_CLK_MHZ;
	typedef enum {OTPPA_RUN, OTPPA_PROG} otppa_mode_e;
	typedef enum {OTPPA_CLK_SINGLE, OTPPA_CLK_DUAL} otppa_clk_e;
endpackage

// ===== hw/otppa_pulse_det.sv
`timescale 1ns/1ps
// measures one low program strobe; reports a write when it lasted long enough
module otppa_pulse_det
	import otppa_pkg::*;
#(
	parameter int MIN_CYC = OTPPA_PULSE_CYC
)(
	input wire logic i_clk, // clock
	input wire logic i_rst, // async reset
	input wire logic i_strobe_n, // program strobe, low active
	input wire logic i_armed, // programming allowed
	output logic o_fire // one-cycle write request
);
	localparam int CW = $clog2(MIN_CYC + 1);
	logic [CW-1:0] cnt_q;
	logic prev_n_q;
	logic ok;
	initial if (MIN_CYC < 1) $error("MIN_CYC must be at least 1");
	assign ok = (cnt_q >= CW'(MIN_CYC));
	always_ff @(posedge i_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			cnt_q <= '0;
			prev_n_q <= 1'b1;
			o_fire <= 1'b0;
		end
		else
		begin
			prev_n_q <= i_strobe_n;
			// saturate so a long pulse still counts once
			if (!i_strobe_n && i_armed && !ok)
				cnt_q <= cnt_q + CW'(1);
			else if (i_strobe_n)
				cnt_q <= '0;
			o_fire <= i_strobe_n && !prev_n_q && ok && i_armed;
		end
	end
endmodule

// ===== test/otppa_prog_model.sv
`timescale 1ns/1ps
// stands in for the external programmer at the parallel port
module otppa_prog_model
	import otppa_pkg::*;
#(
	parameter int PULSE = 4
)(
	input wire logic i_clk, // clock
	input wire logic [OTPPA_DW-1:0] i_data, // resolved data pins
	output logic [OTPPA_PAW-1:0] o_addr, // address pins
	output logic [OTPPA_DW-1:0] o_data, // data to pins
	output logic o_drive, // programmer drives data
	output logic o_ce_n, // chip select
	output logic o_oe_n, // output enable
	output logic o_strobe_n // program strobe
);
	initial {o_addr, o_data, o_drive, o_ce_n, o_oe_n, o_strobe_n} = {17'h00000, 8'h00, 4'h7};
	task automatic rd(input logic [16:0] a, output logic [7:0] d);
		@(negedge i_clk);
		{o_addr, o_drive, o_ce_n, o_oe_n} = {a, 3'b000};
		repeat (2) @(negedge i_clk);
		d = i_data;
		{o_ce_n, o_oe_n} = 2'b11;
	endtask
	// no signature read: high voltage on an address pin would harm the part
	task automatic wr(input logic [16:0] a, input logic [7:0] d, output int tries);
		logic [7:0] back;
		tries = 0;
		do
		begin
			@(negedge i_clk);
			{o_addr, o_data, o_drive, o_ce_n} = {a, d, 2'b10};
			@(negedge i_clk);
			o_strobe_n = 1'b0;
			repeat (PULSE + 1) @(negedge i_clk);
			o_strobe_n = 1'b1;
			// data held until the write lands two edges after the rise
			repeat (3) @(negedge i_clk);
			o_drive = 1'b0;
			tries++;
			rd(a, back);
		end
		while (back !== d && tries < 25);
	endtask
endmodule

// ===== test/otppa_top_tb_top.sv
`timescale 1ns/1ps
module otppa_top_tb_top;
	import otppa_pkg::*;
	logic clk = 1'b0, rst = 1'b1, tpin = 1'b0, shi = 1'b0, slo = 1'b1, rpin = 1'b1, ctl = 1'b0;
	logic cpu_rd = 1'b0, cpu_wr = 1'b0, drive, ce_n, oe_n, stb_n, doe, hit, run, pmode, single;
	logic [19:0] cpu_addr = 20'h00000;
	logic [7:0] wdata = 8'h00, mdata, pins, dout, crdata, d;
	logic [16:0] paddr;
	int errors = 0, n_checks = 0, tries;
	always #10 clk = ~clk;
	// released pins show the inverse of what was last driven
	assign pins = doe ? dout : (drive ? mdata : ~mdata);
	otppa_top #(.PULSE_CYC(4)) u_otppa_top (.I_CLK(clk), .I_SYS_RST(rst), .I_TEST_PIN(tpin), .I_STRAP_HI(shi),
		.I_STRAP_LO(slo), .I_RESET_PIN(rpin), .I_CPU_ADDR(cpu_addr), .I_CPU_RD(cpu_rd), .I_CPU_WR(cpu_wr),
		.I_CPU_WDATA(wdata), .I_PROG_ADDR(paddr), .I_DATA_IN(pins), .I_CHIP_SEL_N(ce_n), .I_OUT_EN_N(oe_n),
		.I_PROGRAM_STROBE_N(stb_n), .I_PROG_MODE_CONTROL_IN(ctl), .O_DATA_OUT(dout), .O_DATA_OE(doe),
		.O_CPU_RDATA(crdata), .O_CPU_HIT(hit), .O_CPU_RUN(run), .O_ARRAY_PROGRAM_MODE(pmode), .O_SINGLE_CLK(single));
	otppa_prog_model #(.PULSE(4)) u_otppa_prog_model (.i_clk(clk), .i_data(pins), .o_addr(paddr), .o_data(mdata),
		.o_drive(drive), .o_ce_n(ce_n), .o_oe_n(oe_n), .o_strobe_n(stb_n));
	task automatic check(input string what, input logic [19:0] seen, input logic [19:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			errors++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic close_out();
		if (errors == 0 && n_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic cpu(input logic [19:0] a, input logic w, input logic [7:0] v, input logic [7:0] exp, input logic h);
		@(negedge clk);
		{cpu_addr, cpu_wr, cpu_rd, wdata} = {a, w, ~w, v};
		@(negedge clk);
		{cpu_wr, cpu_rd} = 2'b00;
		if (!w)
		begin
			check("hit", hit, h);
			if (h)
				check("cpu data", crdata, exp);
		end
	endtask
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_run();
		check("single clock", single, 1'b1);
		check("run", run, 1'b1);
		@(negedge clk) tpin = 1'b1;
		repeat (2) @(negedge clk);
		check("run test high", run, 1'b0);
		tpin = 1'b0;
		repeat (2) @(negedge clk);
	endtask
	task automatic t_ram();
		cpu(20'h00040, 1, 8'hA5, 8'h00, 0);
		cpu(20'h0023F, 1, 8'h5A, 8'h00, 0);
		cpu(20'h00F7F, 1, 8'hC3, 8'h00, 0);
		cpu(20'h00040, 0, 8'h00, 8'hA5, 1);
		cpu(20'h0023F, 0, 8'h00, 8'h5A, 1);
		cpu(20'h00F7F, 0, 8'h00, 8'hC3, 1);
	endtask
	task automatic t_prog();
		{tpin, shi, slo, rpin, ctl} = 5'b11001;
		repeat (3) @(negedge clk);
		check("prog mode", pmode, 1'b1);
		cpu(20'h04000, 0, 8'h00, 8'h00, 0);
		u_otppa_prog_model.wr(17'h00000, 8'h00, tries);
		check("tries low", tries, 1);
		u_otppa_prog_model.wr(17'h03FFF, 8'h00, tries);
		check("tries top", tries, 1);
		u_otppa_prog_model.rd(17'h04000, d);
		check("beyond array", d, OTPPA_BLANK);
		u_otppa_prog_model.rd(17'h00000, d);
		check("verify low", d, 8'h00);
		repeat (2) @(negedge clk);
		check("pins released", doe, 1'b0);
		{tpin, shi, slo, rpin, ctl} = 5'b00110;
		repeat (3) @(negedge clk);
	endtask
	task automatic t_map();
		cpu(OTPPA_LO_BASE, 0, 8'h00, 8'h00, 1);
		cpu(OTPPA_HI_LAST, 0, 8'h00, 8'h00, 1);
	endtask
	initial
	begin
		repeat (4) @(negedge clk);
		rst = 1'b0;
		repeat (2) @(negedge clk);
		t_run();
		t_ram();
		t_prog();
		t_map();
		close_out();
	end
	initial
	begin
		repeat (20000) @(posedge clk);
		errors++;
		close_out();
	end
endmodule
